//--- hw/tmf_top.sv
// TX modulation and frequency configuration bank with serial register port
`timescale 1ns/1ns
module tmf_top
  import tmf_pkg::*;
(
  // Clocks and reset
  input wire logic mclk,
  input wire logic rst,
  input wire logic serial_clk,
  // Serial register port
  input wire logic serial_select_n,
  input wire logic serial_in,
  output logic serial_out,
  output logic serial_out_en,
  // Direct data pin
  input wire logic gpio_tx_data,
  // Modem bit timing
  input wire logic tx_enable,
  input wire logic tx_bit_strobe,
  // Transmit FIFO
  output logic fifo_push,
  output logic [7:0] fifo_push_data,
  output logic fifo_pop,
  input wire logic [7:0] fifo_rd_data,
  input wire logic [6:0] fifo_level,
  output logic fifo_almost_full,
  output logic fifo_almost_empty,
  // Modulator
  output logic tx_data_out,
  output logic pa_key,
  output logic fsk_dir,
  output logic [1:0] mod_type,
  output logic [8:0] deviation_value,
  output logic [18:0] deviation_hz,
  output logic [9:0] offset_value,
  output logic [23:0] carrier_khz,
  output logic high_band,
  output logic side_band,
  output logic alternate_amp_sequence,
  output logic [2:0] rcosc_trim,
  // TX data clock routing
  output logic txclk_gpio,
  output logic txclk_sdo,
  output logic txclk_irq,
  output logic gfsk_clk_missing,
  // Packet handler
  input wire logic [7:0] pkt_length,
  input wire logic last_byte,
  input wire logic [2:0] bit_index,
  output logic [7:0] payload_length,
  output logic len_includes_crc,
  output logic turn_shift
);

  // ----------------------------------------------------------------
  // Serial link domain
  // ----------------------------------------------------------------
  logic frame_rst;
  logic [2:0] bit_cnt_q;
  logic [6:0] sh_q;
  tmf_phase_t phase_q;
  logic wr_q;
  logic [6:0] addr_q;
  logic [7:0] rd_byte_q;
  logic [7:0] bank_s_q [NREG];
  logic [6:0] slot_addr_q [2];
  logic [7:0] slot_data_q [2];
  logic tgl_q;
  logic [7:0] byte_in;
  logic byte_done;
  logic [6:0] rd_addr_d;
  logic [6:0] rd_rel;
  logic [7:0] rd_val_d;
  logic wr_rel_ok;
  logic [6:0] wr_rel;

  // Frame state is cleared by the frame's own select line
  assign frame_rst = rst | serial_select_n;
  assign byte_in = {sh_q, serial_in};
  assign byte_done = (bit_cnt_q == 3'h7);
  assign wr_rel = addr_q - ADDR_MOD2;
  assign wr_rel_ok = (addr_q >= ADDR_MOD2) && (addr_q <= ADDR_AEMPTY);

  always_ff @(posedge serial_clk or posedge frame_rst) begin
    if (frame_rst) begin
      bit_cnt_q <= 3'h0;
      sh_q <= 7'h00;
    end else begin
      bit_cnt_q <= bit_cnt_q + 3'h1;
      sh_q <= byte_in[6:0];
    end
  end

  // Next readback address
  always_comb begin
    if (phase_q == PH_CMD) begin
      rd_addr_d = byte_in[6:0];
    end else if (addr_q == ADDR_FIFO) begin
      rd_addr_d = addr_q;
    end else begin
      rd_addr_d = addr_q + 7'h01;
    end
    rd_rel = rd_addr_d - ADDR_MOD2;
    if ((rd_addr_d >= ADDR_MOD2) && (rd_addr_d <= ADDR_AEMPTY)) begin
      rd_val_d = bank_s_q[rd_rel[3:0]];
    end else begin
      rd_val_d = 8'h00;
    end
  end

  // Command byte then burst of data bytes
  always_ff @(posedge serial_clk or posedge frame_rst) begin
    if (frame_rst) begin
      phase_q <= PH_CMD;
      wr_q <= 1'b0;
      addr_q <= 7'h00;
      rd_byte_q <= 8'h00;
    end else if (byte_done) begin
      rd_byte_q <= rd_val_d;
      if (phase_q == PH_CMD) begin
        phase_q <= PH_DATA;
        wr_q <= byte_in[7];
        addr_q <= byte_in[6:0];
      end else begin
        addr_q <= rd_addr_d;
      end
    end
  end

  // Readback copy of the bank
  generate
    for (genvar i = 0; i < NREG; i++) begin : g_bank_s
      always_ff @(posedge serial_clk or posedge rst) begin
        if (rst) begin
          bank_s_q[i] <= RST_VAL[i];
        end else if (byte_done && phase_q == PH_DATA && wr_q && wr_rel_ok &&
                     wr_rel[3:0] == 4'(i)) begin
          bank_s_q[i] <= byte_in & WR_MASK[i];
        end
      end
    end
  endgenerate

  // Every written byte leaves through one of two alternating slots
  always_ff @(posedge serial_clk or posedge rst) begin
    if (rst) begin
      tgl_q <= 1'b0;
      slot_addr_q[0] <= 7'h00;
      slot_addr_q[1] <= 7'h00;
      slot_data_q[0] <= 8'h00;
      slot_data_q[1] <= 8'h00;
    end else if (byte_done && phase_q == PH_DATA && wr_q) begin
      slot_addr_q[tgl_q] <= addr_q;
      slot_data_q[tgl_q] <= byte_in;
      tgl_q <= ~tgl_q;
    end
  end

  // Read data changes on falling edges for the host's rising sample
  always_ff @(negedge serial_clk or posedge frame_rst) begin
    if (frame_rst) begin
      serial_out <= 1'b0;
      serial_out_en <= 1'b0;
    end else begin
      serial_out <= rd_byte_q[~bit_cnt_q];
      serial_out_en <= (phase_q == PH_DATA) && !wr_q;
    end
  end

  // ----------------------------------------------------------------
  // Main clock domain: synchronisers and bank
  // ----------------------------------------------------------------
  logic tgl_s1_q, tgl_s2_q, seen_q;
  logic sel_s1_q, sel_s2_q;
  logic sin_s1_q, sin_s2_q;
  logic gpio_s1_q, gpio_s2_q;
  logic [7:0] bank_m_q [NREG];
  logic [6:0] xa;
  logic [6:0] x_rel;
  logic x_ok;
  logic x_new;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tgl_s1_q <= 1'b0;
      tgl_s2_q <= 1'b0;
      sel_s1_q <= 1'b1;
      sel_s2_q <= 1'b1;
      sin_s1_q <= 1'b0;
      sin_s2_q <= 1'b0;
      gpio_s1_q <= 1'b0;
      gpio_s2_q <= 1'b0;
    end else begin
      tgl_s1_q <= tgl_q;
      tgl_s2_q <= tgl_s1_q;
      sel_s1_q <= serial_select_n;
      sel_s2_q <= sel_s1_q;
      sin_s1_q <= serial_in;
      sin_s2_q <= sin_s1_q;
      gpio_s1_q <= gpio_tx_data;
      gpio_s2_q <= gpio_s1_q;
    end
  end

  assign x_new = (tgl_s2_q != seen_q);
  assign xa = slot_addr_q[seen_q];
  assign x_rel = xa - ADDR_MOD2;
  assign x_ok = (xa >= ADDR_MOD2) && (xa <= ADDR_AEMPTY);

  // Bytes to the FIFO address become pushes
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      seen_q <= 1'b0;
      fifo_push <= 1'b0;
      fifo_push_data <= 8'h00;
    end else begin
      fifo_push <= x_new && (xa == ADDR_FIFO);
      if (x_new) begin
        seen_q <= ~seen_q;
      end
      // Push data only moves with a push, not with ordinary register writes
      if (x_new && xa == ADDR_FIFO) begin
        fifo_push_data <= slot_data_q[seen_q];
      end
    end
  end

  generate
    for (genvar i = 0; i < NREG; i++) begin : g_bank_m
      always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
          bank_m_q[i] <= RST_VAL[i];
        end else if (x_new && x_ok && x_rel[3:0] == 4'(i)) begin
          bank_m_q[i] <= slot_data_q[seen_q] & WR_MASK[i];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Field decode
  // ----------------------------------------------------------------
  tmf_clkr_t clk_route;
  tmf_src_t src;
  tmf_mod_t mtype;
  logic inv;
  logic [8:0] dev_word;
  logic [9:0] ofs_word;
  logic hb;
  logic [4:0] band_code;
  logic [15:0] car_word;

  assign clk_route = tmf_clkr_t'(bank_m_q[IDX_MOD2][POS_TRCLK +: 2]);
  assign src = tmf_src_t'(bank_m_q[IDX_MOD2][POS_DTMOD +: 2]);
  assign mtype = tmf_mod_t'(bank_m_q[IDX_MOD2][POS_MODTYP +: 2]);
  assign inv = bank_m_q[IDX_MOD2][POS_INV];
  // Deviation MSB joins its low register
  assign dev_word = {bank_m_q[IDX_MOD2][POS_DEV_MSB], bank_m_q[IDX_DEV_LO]};
  // Offset high bits in low bits of second register
  assign ofs_word = {bank_m_q[IDX_OFS_HI][1:0], bank_m_q[IDX_OFS_LO]};
  assign hb = bank_m_q[IDX_BAND][POS_HBSEL];
  assign band_code = bank_m_q[IDX_BAND][POS_BAND +: 5];
  assign car_word = {bank_m_q[IDX_FC_HI], bank_m_q[IDX_FC_LO]};

  // ----------------------------------------------------------------
  // Frequency arithmetic
  // ----------------------------------------------------------------
  logic signed [27:0] car_a, car_b, car_c;
  logic [19:0] hop_khz;
  logic [23:0] carrier_d;

  always_comb begin
    // Band code scaled by the band width via the range multiplier
    car_a = (28'(band_code) + BAND_BIAS) * CARRIER_FRAC + 28'(car_word) +
            {{18{ofs_word[9]}}, ofs_word};
    car_b = car_a * (hb ? CARRIER_MUL_HI : CARRIER_MUL_LO);
    car_c = car_b >>> CARRIER_SHIFT;
    hop_khz = 20'(bank_m_q[IDX_HOP_CH]) * 20'(bank_m_q[IDX_HOP_STEP]) * HOP_STEP_KHZ;
    carrier_d = car_c[23:0] + 24'(hop_khz);
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      carrier_khz <= 24'h00_0000;
      deviation_value <= 9'h000;
      deviation_hz <= 19'h0_0000;
      offset_value <= 10'h000;
      high_band <= 1'b0;
      side_band <= 1'b0;
      mod_type <= 2'h0;
      alternate_amp_sequence <= 1'b0;
      rcosc_trim <= 3'h0;
    end else begin
      carrier_khz <= carrier_d;
      deviation_value <= dev_word;
      deviation_hz <= 19'(dev_word) * DEV_STEP_HZ;
      offset_value <= ofs_word;
      high_band <= hb;
      side_band <= bank_m_q[IDX_BAND][POS_SBSEL];
      mod_type <= mtype;
      alternate_amp_sequence <= bank_m_q[IDX_MISC][POS_ALT_PA];
      rcosc_trim <= bank_m_q[IDX_MISC][POS_RCCAL +: 3];
    end
  end

  // ----------------------------------------------------------------
  // Transmit data path
  // ----------------------------------------------------------------
  logic [8:0] pn9_q;
  logic [7:0] fbits_q;
  logic [2:0] fcnt_q;
  logic dir_q;
  logic bit_d;
  logic step;

  assign step = tx_enable && tx_bit_strobe;

  always_comb begin
    unique case (src)
      SRC_GPIO: bit_d = gpio_s2_q;
      SRC_SERIAL: bit_d = sel_s2_q ? sin_s2_q : dir_q;
      SRC_FIFO: bit_d = (fcnt_q == 3'h0) ? (fifo_rd_data[7] && fifo_level != 7'h00)
                                         : fbits_q[7];
      SRC_PN9: bit_d = pn9_q[8];
    endcase
  end

  // PN9 sequence, x^9 + x^5 + 1
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pn9_q <= PN9_SEED;
    end else if (step && src == SRC_PN9) begin
      pn9_q <= {pn9_q[7:0], pn9_q[8] ^ pn9_q[4]};
    end
  end

  // FIFO bytes go out MSB first; an empty FIFO forces only the MSB of the byte to zero
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      fbits_q <= 8'h00;
      fcnt_q <= 3'h0;
      fifo_pop <= 1'b0;
    end else begin
      fifo_pop <= 1'b0;
      if (step && src == SRC_FIFO) begin
        fcnt_q <= fcnt_q + 3'h1;
        if (fcnt_q == 3'h0) begin
          fbits_q <= {fifo_rd_data[6:0], 1'b0};
          fifo_pop <= (fifo_level != 7'h00);
        end else begin
          fbits_q <= {fbits_q[6:0], 1'b0};
        end
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      dir_q <= 1'b0;
      tx_data_out <= 1'b0;
      pa_key <= 1'b0;
      fsk_dir <= 1'b0;
    end else begin
      if (step) begin
        dir_q <= bit_d;
        tx_data_out <= bit_d ^ inv;
      end
      pa_key <= tx_enable && (mtype != MOD_OOK || tx_data_out);
      fsk_dir <= tx_enable && (mtype == MOD_FSK || mtype == MOD_GFSK) && tx_data_out;
    end
  end

  // Bit clock routed to the selected pin
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      txclk_gpio <= 1'b0;
      txclk_sdo <= 1'b0;
      txclk_irq <= 1'b0;
      gfsk_clk_missing <= 1'b0;
    end else begin
      txclk_gpio <= step && clk_route == CLK_GPIO;
      txclk_sdo <= step && clk_route == CLK_SDO;
      txclk_irq <= step && clk_route == CLK_IRQ;
      // Direct GFSK without a data clock
      gfsk_clk_missing <= mtype == MOD_GFSK && clk_route == CLK_NONE &&
                          (src == SRC_GPIO || src == SRC_SERIAL);
    end
  end

  // ----------------------------------------------------------------
  // FIFO thresholds and packet settings
  // ----------------------------------------------------------------
  logic len_crc;
  assign len_crc = bank_m_q[IDX_TURN][POS_LEN_CRC];

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      fifo_almost_full <= 1'b0;
      fifo_almost_empty <= 1'b1;
      payload_length <= 8'h00;
      len_includes_crc <= 1'b0;
      turn_shift <= 1'b0;
    end else begin
      fifo_almost_full <= fifo_level > {1'b0, bank_m_q[IDX_AFULL][5:0]};
      fifo_almost_empty <= fifo_level <= {1'b0, bank_m_q[IDX_AEMPTY][5:0]};
      // Strip CRC bytes from length when counted
      payload_length <= len_crc ? pkt_length - CRC_BYTES : pkt_length;
      len_includes_crc <= len_crc;
      turn_shift <= bank_m_q[IDX_TURN][POS_TA_EN] && last_byte && tx_bit_strobe &&
                    bit_index == {1'b1, bank_m_q[IDX_TURN][POS_PHASE +: 2]};
    end
  end

endmodule : tmf_top

//--- inc/tmf_pkg.sv
// Package: addresses, layouts, reset values and constants of the TX config bank
package tmf_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [6:0] ADDR_MOD2 = 7'h71;
  localparam logic [6:0] ADDR_DEV_LO = 7'h72;
  localparam logic [6:0] ADDR_OFS_LO = 7'h73;
  localparam logic [6:0] ADDR_OFS_HI = 7'h74;
  localparam logic [6:0] ADDR_BAND = 7'h75;
  localparam logic [6:0] ADDR_FC_HI = 7'h76;
  localparam logic [6:0] ADDR_FC_LO = 7'h77;
  localparam logic [6:0] ADDR_MISC = 7'h78;
  localparam logic [6:0] ADDR_HOP_CH = 7'h79;
  localparam logic [6:0] ADDR_HOP_STEP = 7'h7A;
  localparam logic [6:0] ADDR_TURN = 7'h7B;
  localparam logic [6:0] ADDR_AFULL = 7'h7C;
  localparam logic [6:0] ADDR_AEMPTY = 7'h7D;
  localparam logic [6:0] ADDR_FIFO = 7'h7F;
  localparam int NREG = 13;

  // Bank index of each register (address minus first address)
  localparam logic [3:0] IDX_MOD2 = 4'h0;
  localparam logic [3:0] IDX_DEV_LO = 4'h1;
  localparam logic [3:0] IDX_OFS_LO = 4'h2;
  localparam logic [3:0] IDX_OFS_HI = 4'h3;
  localparam logic [3:0] IDX_BAND = 4'h4;
  localparam logic [3:0] IDX_FC_HI = 4'h5;
  localparam logic [3:0] IDX_FC_LO = 4'h6;
  localparam logic [3:0] IDX_MISC = 4'h7;
  localparam logic [3:0] IDX_HOP_CH = 4'h8;
  localparam logic [3:0] IDX_HOP_STEP = 4'h9;
  localparam logic [3:0] IDX_TURN = 4'hA;
  localparam logic [3:0] IDX_AFULL = 4'hB;
  localparam logic [3:0] IDX_AEMPTY = 4'hC;

  typedef logic [7:0] tmf_byte_t;

  // Reset values and writable-bit masks, in bank index order
  localparam tmf_byte_t RST_VAL [NREG] = '{8'h00, 8'h20, 8'h00, 8'h00, 8'h75, 8'hBB, 8'h80,
                                           8'h00, 8'h00, 8'h00, 8'h7B, 8'h00, 8'h04};
  localparam tmf_byte_t WR_MASK [NREG] = '{8'hFF, 8'hFF, 8'hFF, 8'h03, 8'h7F, 8'hFF, 8'hFF,
                                           8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h3F, 8'h3F};

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int POS_TRCLK = 6;
  localparam int POS_DTMOD = 4;
  localparam int POS_INV = 3;
  localparam int POS_DEV_MSB = 2;
  localparam int POS_MODTYP = 0;
  localparam int POS_SBSEL = 6;
  localparam int POS_HBSEL = 5;
  localparam int POS_BAND = 0;
  localparam int POS_ALT_PA = 3;
  localparam int POS_RCCAL = 0;
  localparam int POS_LEN_CRC = 7;
  localparam int POS_TA_EN = 2;
  localparam int POS_PHASE = 0;

  // ----------------------------------------------------------------
  // Arithmetic constants
  // ----------------------------------------------------------------
  localparam logic signed [27:0] BAND_BIAS = 28'sd24;
  localparam logic signed [27:0] CARRIER_FRAC = 28'sd64000;
  // 10000 / 64000 == 5 / 32; high band doubles the multiplier
  localparam logic signed [27:0] CARRIER_MUL_LO = 28'sd5;
  localparam logic signed [27:0] CARRIER_MUL_HI = 28'sd10;
  localparam int CARRIER_SHIFT = 5;
  localparam logic [19:0] HOP_STEP_KHZ = 20'd10;
  localparam logic [18:0] DEV_STEP_HZ = 19'd625;
  localparam logic [7:0] CRC_BYTES = 8'd2;
  localparam logic [8:0] PN9_SEED = 9'h1FF;

  typedef enum logic [1:0] {SRC_GPIO, SRC_SERIAL, SRC_FIFO, SRC_PN9} tmf_src_t;
  typedef enum logic [1:0] {MOD_CW, MOD_OOK, MOD_FSK, MOD_GFSK} tmf_mod_t;
  typedef enum logic [1:0] {CLK_NONE, CLK_GPIO, CLK_SDO, CLK_IRQ} tmf_clkr_t;
  typedef enum logic {PH_CMD, PH_DATA} tmf_phase_t;

endpackage : tmf_pkg

//--- testbench/tmf_host_model.sv
// Host serial master model for the configuration port
`timescale 1ns/1ns
module tmf_host_model
  import tmf_pkg::*;
(
  // Serial port
  output logic serial_clk,
  output logic serial_select_n,
  output logic serial_in,
  input wire logic serial_out
);
  initial begin
    serial_clk = 1'b0;
    serial_select_n = 1'b1;
    serial_in = 1'b0;
  end
  task automatic xfer_byte(input tmf_byte_t d, output tmf_byte_t q);
    for (int i = 7; i >= 0; i--) begin
      serial_in = d[i];
      #6 serial_clk = 1'b1;
      q[i] = serial_out;
      #6 serial_clk = 1'b0;
    end
  endtask : xfer_byte
  task automatic open_frame();
    serial_select_n = 1'b0;
    #7;
  endtask : open_frame
  task automatic close_frame();
    #7 serial_select_n = 1'b1;
    serial_in = ~serial_in;
    #12;
  endtask : close_frame
  task automatic direct_bit(input logic b);
    serial_in = b;
  endtask : direct_bit
endmodule : tmf_host_model

//--- testbench/tmf_top_checker.sv
// Port-level assertions for the TX configuration bank
`timescale 1ns/1ns
module tmf_top_checker
  import tmf_pkg::*;
(
  // Clocks and reset
  input wire logic mclk,
  input wire logic rst,
  input wire logic serial_clk,
  // Inputs
  input wire logic serial_select_n,
  input wire logic tx_enable,
  input wire logic tx_bit_strobe,
  input wire logic [6:0] fifo_level,
  input wire logic [7:0] pkt_length,
  input wire logic last_byte,
  input wire logic [2:0] bit_index,
  // Outputs
  input wire logic serial_out_en,
  input wire logic fifo_push,
  input wire logic [7:0] fifo_push_data,
  input wire logic fifo_pop,
  input wire logic tx_data_out,
  input wire logic fsk_dir,
  input wire logic [1:0] mod_type,
  input wire logic [8:0] deviation_value,
  input wire logic [18:0] deviation_hz,
  input wire logic txclk_gpio,
  input wire logic txclk_sdo,
  input wire logic txclk_irq,
  input wire logic [7:0] payload_length,
  input wire logic len_includes_crc,
  input wire logic turn_shift
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  sequence s_step;
    tx_enable && tx_bit_strobe;
  endsequence
  sequence s_mark_fsk;
    tx_enable && tx_data_out && mod_type[1] && $stable(mod_type);
  endsequence
  AST_TXCLK_ONE: assert property ($onehot0({txclk_gpio, txclk_sdo, txclk_irq}))
    else $error("two clock routes pulsed");
  AST_TXCLK_STEP: assert property ((txclk_gpio || txclk_sdo || txclk_irq)
    |-> $past(tx_enable && tx_bit_strobe)) else $error("clock pulse without step");
  AST_FSK_SET: assert property (s_step ##1 s_mark_fsk |=> fsk_dir)
    else $error("fsk direction missed");
  AST_FSK_CAUSE: assert property (fsk_dir |-> $past(tx_enable && tx_data_out))
    else $error("fsk direction without mark");
  AST_POP_STEP: assert property (fifo_pop |-> $past(tx_enable && tx_bit_strobe)
    && $past(fifo_level) != 7'h00) else $error("pop without step");
  AST_PUSH_HOLD: assert property (!fifo_push |-> $stable(fifo_push_data))
    else $error("push data moved");
  AST_DEV_HZ: assert property ($stable(deviation_value)
    |-> deviation_hz == 19'(deviation_value) * 19'd625) else $error("deviation hz");
  AST_PAYLOAD: assert property ($stable(pkt_length) && $stable(len_includes_crc)
    |-> payload_length == (len_includes_crc ? pkt_length - 8'd2 : pkt_length))
    else $error("payload length");
  AST_TURN: assert property (turn_shift
    |-> $past(last_byte && tx_bit_strobe && bit_index[2])) else $error("turn shift");
  AST_SEL_FRAME: assert property (@(posedge serial_clk) disable iff (rst)
    serial_out_en |-> !serial_select_n) else $error("read drive outside frame");
endmodule : tmf_top_checker

bind tmf_top tmf_top_checker u_checker (.mclk, .rst, .serial_clk, .serial_select_n,
  .tx_enable, .tx_bit_strobe, .fifo_level, .pkt_length, .last_byte, .bit_index,
  .serial_out_en, .fifo_push, .fifo_push_data, .fifo_pop, .tx_data_out, .fsk_dir,
  .mod_type, .deviation_value, .deviation_hz, .txclk_gpio, .txclk_sdo, .txclk_irq,
  .payload_length, .len_includes_crc, .turn_shift);

//--- testbench/tmf_top_tb.sv
// Self-checking bench for the TX configuration bank
`timescale 1ns/1ns
module tmf_top_tb;
  import tmf_pkg::*;
  logic mclk, rst, serial_clk, serial_select_n, serial_in, serial_out, serial_out_en;
  logic gpio_tx_data, tx_enable, tx_bit_strobe, fifo_push, fifo_pop, fifo_almost_full;
  logic fifo_almost_empty, tx_data_out, pa_key, fsk_dir, high_band, side_band;
  logic alternate_amp_sequence, txclk_gpio, txclk_sdo, txclk_irq, gfsk_clk_missing;
  logic last_byte, len_includes_crc, turn_shift;
  logic [7:0] fifo_push_data, fifo_rd_data, pkt_length, payload_length;
  logic [6:0] fifo_level;
  logic [1:0] mod_type;
  logic [8:0] deviation_value;
  logic [18:0] deviation_hz;
  logic [9:0] offset_value;
  logic [23:0] carrier_khz;
  logic [2:0] rcosc_trim, bit_index;
  int n_errors = 0;
  int n_compared = 0;
  int n_pops = 0;
  int ones;
  tmf_byte_t pushed[$];

  tmf_top DUT (.mclk, .rst, .serial_clk, .serial_select_n, .serial_in, .serial_out,
    .serial_out_en, .gpio_tx_data, .tx_enable, .tx_bit_strobe, .fifo_push, .fifo_push_data,
    .fifo_pop, .fifo_rd_data, .fifo_level, .fifo_almost_full, .fifo_almost_empty,
    .tx_data_out, .pa_key, .fsk_dir, .mod_type, .deviation_value, .deviation_hz,
    .offset_value, .carrier_khz, .high_band, .side_band, .alternate_amp_sequence,
    .rcosc_trim, .txclk_gpio, .txclk_sdo, .txclk_irq, .gfsk_clk_missing, .pkt_length,
    .last_byte, .bit_index, .payload_length, .len_includes_crc, .turn_shift);
  tmf_host_model host (.serial_clk, .serial_select_n, .serial_in, .serial_out);

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    if (fifo_push === 1'b1) pushed.push_back(fifo_push_data);
    if (fifo_pop === 1'b1) n_pops++;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Writes n bytes from the given address; mclk side settles within 6 cycles
  task automatic reg_wr(input logic [6:0] a, input int n, input tmf_byte_t d0, d1, d2);
    tmf_byte_t q;
    tmf_byte_t d[3];
    d = '{d0, d1, d2};
    host.open_frame();
    host.xfer_byte({1'b1, a}, q);
    for (int i = 0; i < n; i++) host.xfer_byte(d[i], q);
    host.close_frame();
    repeat (6) @(negedge mclk);
  endtask : reg_wr
  task automatic reg_rd(input logic [6:0] a, input tmf_byte_t exp);
    tmf_byte_t q;
    host.open_frame();
    host.xfer_byte({1'b0, a}, q);
    host.xfer_byte(8'h00, q);
    host.close_frame();
    @(negedge mclk);
    check(q, exp);
  endtask : reg_rd
  task automatic step();
    @(negedge mclk);
    tx_bit_strobe = 1'b1;
    @(negedge mclk);
    tx_bit_strobe = 1'b0;
  endtask : step
  function automatic longint khz(longint band, hb, car, ofs, hch, hs);
    return ((band + 24) * 64000 + car + ofs) * 10000 * (hb + 1) / 64000 + hch * hs * 10;
  endfunction : khz
  task automatic close_out();
    $display("Compared %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : close_out

  initial begin
    #1_000_000;
    n_errors++;
    close_out();
  end
  initial begin
    {rst, gpio_tx_data, tx_enable, tx_bit_strobe, last_byte} = 5'b1_0000;
    {fifo_rd_data, fifo_level, pkt_length, bit_index} = '0;
    repeat (4) @(negedge mclk);
    rst = 1'b0;
    @(negedge mclk);
    check(fifo_almost_empty, 1);
    for (int i = 0; i < NREG; i++) reg_rd(ADDR_MOD2 + 7'(i), RST_VAL[i]);
    reg_rd(7'h70, 8'h00);
    reg_rd(ADDR_FIFO, 8'h00);
    check(carrier_khz, 32'(khz(21, 1, 48000, 0, 0, 0)));
    $display("Test reset done");
    // deviation driven to its full 9-bit maximum
    reg_wr(ADDR_DEV_LO, 1, 8'hFF, 8'h00, 8'h00);
    reg_wr(ADDR_MOD2, 1, 8'h04, 8'h00, 8'h00);
    check(deviation_value, 9'h1FF);
    check(deviation_hz, 625 * 511);
    reg_wr(ADDR_HOP_CH, 2, 8'h05, 8'h0A, 8'h00);
    check(carrier_khz, 32'(khz(21, 1, 48000, 0, 5, 10)));
    reg_wr(ADDR_OFS_LO, 2, 8'hC0, 8'hFF, 8'h00);
    check(offset_value, 10'h3C0);
    reg_rd(ADDR_OFS_HI, 8'h03);
    check(carrier_khz, 32'(khz(21, 1, 48000, -64, 5, 10)));
    reg_wr(ADDR_BAND, 1, 8'hC0, 8'h00, 8'h00);
    reg_rd(ADDR_BAND, 8'h40);
    check({high_band, side_band}, 2'b01);
    check(carrier_khz, 32'(khz(0, 0, 48000, -64, 5, 10)));
    reg_wr(ADDR_BAND, 1, 8'h01, 8'h00, 8'h00);
    check(carrier_khz, 32'(khz(1, 0, 48000, -64, 5, 10)));
    reg_wr(ADDR_BAND, 1, 8'h20, 8'h00, 8'h00);
    check(carrier_khz, 32'(khz(0, 1, 48000, -64, 5, 10)));
    $display("Test frequency done");
    // trim left at its reset value
    reg_wr(ADDR_MISC, 1, 8'h08, 8'h00, 8'h00);
    check({alternate_amp_sequence, rcosc_trim}, 4'h8);
    reg_wr(ADDR_TURN, 1, 8'h86, 8'h00, 8'h00);
    pkt_length = 8'h09;
    repeat (2) @(negedge mclk);
    check(payload_length, 8'h07);
    check(len_includes_crc, 1);
    {last_byte, bit_index} = 4'b1_101;
    step();
    check(turn_shift, 0);
    bit_index = 3'd6;
    step();
    check(turn_shift, 1);
    reg_wr(ADDR_AFULL, 1, 8'hC5, 8'h00, 8'h00);
    reg_rd(ADDR_AFULL, 8'h05);
    for (int lv = 4; lv <= 6; lv++) begin
      fifo_level = 7'(lv);
      repeat (2) @(negedge mclk);
      check({fifo_almost_full, fifo_almost_empty}, {lv > 5, lv <= 4});
    end
    reg_wr(ADDR_FIFO, 3, 8'hA5, 8'h3C, 8'h0F);
    check(pushed.size(), 3);
    for (int i = 0; i < 3; i++) check(pushed[i], i == 0 ? 8'hA5 : i == 1 ? 8'h3C : 8'h0F);
    reg_rd(ADDR_TURN, 8'h86);
    $display("Test control done");
    {tx_enable, gpio_tx_data} = 2'b11;
    for (int rt = 1; rt <= 3; rt++) begin
      reg_wr(ADDR_MOD2, 1, {2'(rt), 6'h02}, 8'h00, 8'h00);
      step();
      check({tx_data_out, txclk_irq, txclk_sdo, txclk_gpio}, 4'h8 | 4'(1 << (rt - 1)));
      @(negedge mclk);
      check({fsk_dir, pa_key}, 2'b11);
    end
    reg_wr(ADDR_MOD2, 1, 8'h0A, 8'h00, 8'h00);
    step();
    check(tx_data_out, 0);
    gpio_tx_data = 1'b0;
    reg_wr(ADDR_MOD2, 1, 8'h01, 8'h00, 8'h00);
    step();
    @(negedge mclk);
    check(pa_key, 0);
    reg_wr(ADDR_MOD2, 1, 8'h00, 8'h00, 8'h00);
    step();
    @(negedge mclk);
    check({fsk_dir, pa_key}, 2'b01);
    reg_wr(ADDR_MOD2, 1, 8'h03, 8'h00, 8'h00);
    check(gfsk_clk_missing, 1);
    check(mod_type, 2'h3);
    reg_wr(ADDR_MOD2, 1, 8'h12, 8'h00, 8'h00);
    for (int b = 1; b >= 0; b--) begin
      host.direct_bit(1'(b));
      repeat (4) @(negedge mclk);
      step();
      check(tx_data_out, b);
    end
    host.open_frame();
    host.direct_bit(1'b1);
    repeat (4) @(negedge mclk);
    step();
    check(tx_data_out, 0);
    host.close_frame();
    @(negedge mclk);
    {fifo_rd_data, fifo_level, n_pops, ones} = {8'h80, 7'h01, 32'd0, 32'd0};
    reg_wr(ADDR_MOD2, 1, 8'h22, 8'h00, 8'h00);
    repeat (8) begin
      step();
      ones += tx_data_out;
    end
    check({n_pops[7:0], ones[7:0]}, 16'h0101);
    reg_wr(ADDR_MOD2, 1, 8'h32, 8'h00, 8'h00);
    step();
    check(tx_data_out, 1);
    $display("Test modulation done");
    close_out();
  end
endmodule : tmf_top_tb
